// ===== rtl/netcfg_pkg.sv
// Purpose: Shared constants and types for the network board configuration decoder.
// Assumes: 125 MHz reference clock; switch inputs read 1 when the position is closed (on).
// Notes:   Timing figures are kept in their own unit and converted to cycles here.
package netcfg_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_MHZ        = 125;
  localparam int unsigned HOLD_MIN_MS    = 1000;
  localparam int unsigned HOLD_MAX_MS    = 5000;
  localparam int unsigned FLASH_HALF_MS  = 250;
  localparam int unsigned HOLD_MIN_CYC   = HOLD_MIN_MS * CLK_MHZ * 1000;
  localparam int unsigned HOLD_MAX_CYC   = HOLD_MAX_MS * CLK_MHZ * 1000;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CLK_MHZ * 1000;
  localparam int unsigned CNT_W          = 32;
  localparam int unsigned SETTLE_W       = 3;
  localparam logic [2:0]  SETTLE_CYC     = 3'h5;

  // ****************************************
  // Switch banks and pin vector
  // ****************************************
  localparam int unsigned BANK_A_W       = 10;
  localparam int unsigned BANK_B_W       = 4;
  localparam int unsigned SW_EMUL_A      = 0;
  localparam int unsigned SW_EMUL_B      = 1;
  localparam int unsigned SW_SENSOR      = 3;
  localparam int unsigned SW_INIT        = 4;
  localparam int unsigned SW_BUSY        = 5;
  localparam int unsigned SW_AUTO        = 6;
  localparam int unsigned SW_CONNECT     = 7;
  localparam logic [9:0]  BANK_A_RST     = 10'h3ff;
  localparam logic [3:0]  BANK_B_RST     = 4'hf;

  localparam int unsigned PIN_W          = 18;
  localparam int unsigned PIN_BANK_A_LSB = 0;
  localparam int unsigned PIN_BANK_B_LSB = 10;
  localparam int unsigned PIN_BUTTON     = 14;
  localparam int unsigned PIN_LINK100    = 15;
  localparam int unsigned PIN_RX         = 16;
  localparam int unsigned PIN_INIT_B     = 17;
  localparam logic [17:0] PIN_RST_VAL    = 18'h23fff;

  // ****************************************
  // Emulation codes
  // ****************************************
  localparam logic [1:0]  EMUL_LINE       = 2'h0;
  localparam logic [1:0]  EMUL_PAGE       = 2'h1;
  localparam logic [1:0]  EMUL_UNASSIGNED = 2'h2;
  localparam logic [1:0]  EMUL_THIRD      = 2'h3;

  // ****************************************
  // Register map
  // ****************************************
  localparam int unsigned ADDR_W         = 4;
  localparam int unsigned DATA_W         = 32;
  localparam logic [3:0]  REG_CONFIG     = 4'h0;
  localparam logic [3:0]  REG_DECODE     = 4'h4;
  localparam logic [3:0]  REG_IRQ_STATUS = 4'h8;
  localparam logic [3:0]  REG_IRQ_MASK   = 4'hc;

  localparam int unsigned DEC_EMUL_LSB   = 0;
  localparam int unsigned DEC_SENSOR     = 2;
  localparam int unsigned DEC_BUSY       = 3;
  localparam int unsigned DEC_INIT_EN    = 4;
  localparam int unsigned DEC_AUTO_EN    = 5;
  localparam int unsigned DEC_CONNECT_EN = 6;
  localparam int unsigned DEC_CFG_VALID  = 7;
  localparam int unsigned DEC_BTN_LSB    = 8;

  localparam int unsigned IRQ_W           = 4;
  localparam int unsigned IRQ_PENDING     = 0;
  localparam int unsigned IRQ_RESTORE     = 1;
  localparam int unsigned IRQ_AUTO_RPT    = 2;
  localparam int unsigned IRQ_CONNECT_RPT = 3;
  localparam logic [3:0]  IRQ_MASK_RST    = 4'h0;

  // ****************************************
  // Push-button sequence
  // ****************************************
  typedef enum logic [2:0] {
    BTN_IDLE,
    BTN_HELD,
    BTN_WAIT_RELEASE,
    BTN_PENDING,
    BTN_RESTORE,
    BTN_REBOOT
  } btn_state_type;

endpackage

// ===== rtl/pin_sync_if.sv
// Purpose: Carries raw pin levels to the synchroniser and stable levels back.
// Assumes: One clock domain on the stable side.
// Notes:   Width set by the instantiating module.
`timescale 1ns/100ps
interface pin_sync_if #(parameter int unsigned W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] stable;

  modport drv  (output raw, input stable);
  modport sync (input raw, output stable);
endinterface

// ===== rtl/pin_sync.sv
// Purpose: Three-stage synchroniser for asynchronous pins with agreement filter.
// Assumes: Pins are slow levels relative to the clock.
// Notes:   Stable output moves only when stages two and three agree.
`timescale 1ns/100ps
module pin_sync #(
  parameter int unsigned    W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_b_i,
  pin_sync_if.sync          pins
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] stable_q;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end
    else
    begin
      s1_q <= pins.raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Per bit, a change counts once stages two and three agree
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      stable_q <= RST_VAL;
    else
      stable_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & stable_q);
  end

  assign pins.stable = stable_q;

endmodule

// ===== rtl/netcfg_decoder.sv
// Purpose: Switch-bank decode, busy/status control, factory-reset button and lamps.
// Assumes: Switch inputs read 1 when closed; button_i reads 1 while pressed.
// Notes:   Configuration is latched once after reset and held until the next reset.
`timescale 1ns/100ps
module netcfg_decoder #(
  parameter int unsigned HOLD_MIN_CYC   = netcfg_pkg::HOLD_MIN_CYC,
  parameter int unsigned HOLD_MAX_CYC   = netcfg_pkg::HOLD_MAX_CYC,
  parameter int unsigned FLASH_HALF_CYC = netcfg_pkg::FLASH_HALF_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [9:0]  config_switch_bank_a_i,
  input  wire logic [3:0]  config_switch_bank_b_i,
  input  wire logic        button_i,
  input  wire logic        link_100_i,
  input  wire logic        rx_activity_i,
  input  wire logic        host_init_b_i,
  input  wire logic        offline_i,
  input  wire logic        rx_buf_full_i,
  input  wire logic        status_change_i,
  input  wire logic        port_connect_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  output logic      [31:0] rd_data_o,
  output logic      [1:0]  emulation_o,
  output logic             sensor_adjust_en_o,
  output logic             busy_o,
  output logic             status_report_o,
  output logic             init_reset_o,
  output logic             factory_restore_o,
  output logic             reboot_req_o,
  output logic             led_green_o,
  output logic             led_red_o,
  output logic             irq_o
);

  // ****************************************
  // Pin synchronisation
  // ****************************************
  pin_sync_if #(.W(netcfg_pkg::PIN_W)) pins_if ();

  assign pins_if.raw = {host_init_b_i, rx_activity_i, link_100_i, button_i,
                        config_switch_bank_b_i, config_switch_bank_a_i};

  pin_sync #(
    .W       (netcfg_pkg::PIN_W),
    .RST_VAL (netcfg_pkg::PIN_RST_VAL)
  ) u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .pins      (pins_if.sync)
  );

  logic btn_s;
  logic link_s;
  logic rx_s;
  logic init_b_s;

  assign btn_s    = pins_if.stable[netcfg_pkg::PIN_BUTTON];
  assign link_s   = pins_if.stable[netcfg_pkg::PIN_LINK100];
  assign rx_s     = pins_if.stable[netcfg_pkg::PIN_RX];
  assign init_b_s = pins_if.stable[netcfg_pkg::PIN_INIT_B];

  // ****************************************
  // Configuration latch
  // ****************************************
  logic [2:0] settle_q;
  logic       cfg_valid_q;
  logic [9:0] bank_a_q;
  logic [3:0] bank_b_q;

  // Waits for the synchroniser to fill before sampling, so a stale reset value is never taken
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      settle_q    <= '0;
      cfg_valid_q <= 1'b0;
      bank_a_q    <= netcfg_pkg::BANK_A_RST;
      bank_b_q    <= netcfg_pkg::BANK_B_RST;
    end
    else if (!cfg_valid_q)
    begin
      if (settle_q == netcfg_pkg::SETTLE_CYC)
      begin
        cfg_valid_q <= 1'b1;
        bank_a_q    <= pins_if.stable[netcfg_pkg::PIN_BANK_A_LSB +: netcfg_pkg::BANK_A_W];
        bank_b_q    <= pins_if.stable[netcfg_pkg::PIN_BANK_B_LSB +: netcfg_pkg::BANK_B_W];
      end
      else
        settle_q <= settle_q + 3'h1;
    end
  end

  // ****************************************
  // Decode
  // ****************************************
  logic [1:0] emul_d;
  logic       line_page;
  logic       sensor_en;
  logic       init_en;
  logic       auto_en;
  logic       connect_en;

  always_comb
  begin
    case ({bank_a_q[netcfg_pkg::SW_EMUL_B], bank_a_q[netcfg_pkg::SW_EMUL_A]})
      2'h3:    emul_d = netcfg_pkg::EMUL_LINE;
      2'h2:    emul_d = netcfg_pkg::EMUL_PAGE;
      2'h0:    emul_d = netcfg_pkg::EMUL_THIRD;
      default: emul_d = netcfg_pkg::EMUL_UNASSIGNED;
    endcase
  end

  // Init and connect option meanings depend on the emulation just decoded
  assign line_page  = (emul_d == netcfg_pkg::EMUL_LINE) || (emul_d == netcfg_pkg::EMUL_PAGE);
  assign sensor_en  = !bank_a_q[netcfg_pkg::SW_SENSOR];
  assign init_en    = bank_a_q[netcfg_pkg::SW_INIT] && (emul_d == netcfg_pkg::EMUL_THIRD);
  assign auto_en    = bank_a_q[netcfg_pkg::SW_AUTO];
  assign connect_en = bank_a_q[netcfg_pkg::SW_CONNECT] && line_page;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      emulation_o        <= netcfg_pkg::EMUL_LINE;
      sensor_adjust_en_o <= 1'b0;
      init_reset_o       <= 1'b0;
    end
    else
    begin
      emulation_o        <= emul_d;
      sensor_adjust_en_o <= sensor_en;
      init_reset_o       <= init_en && !init_b_s;
    end
  end

  // ****************************************
  // Busy and status reports
  // ****************************************
  logic auto_rpt;
  logic connect_rpt;

  assign auto_rpt    = auto_en && status_change_i;
  assign connect_rpt = connect_en && port_connect_i;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      busy_o          <= 1'b0;
      status_report_o <= 1'b0;
    end
    else
    begin
      if (bank_a_q[netcfg_pkg::SW_BUSY])
        busy_o <= offline_i || rx_buf_full_i;
      else
        busy_o <= rx_buf_full_i;
      status_report_o <= auto_rpt || connect_rpt;
    end
  end

  // ****************************************
  // Factory-reset button sequence
  // ****************************************
  netcfg_pkg::btn_state_type btn_state_q;
  logic [31:0]               hold_cnt_q;
  logic [31:0]               flash_cnt_q;
  logic                      flash_q;
  logic                      btn_prev_q;
  logic                      btn_rise;
  logic                      btn_fall;
  logic                      pending_enter;

  assign btn_rise      = btn_s && !btn_prev_q;
  assign btn_fall      = !btn_s && btn_prev_q;
  assign pending_enter = (btn_state_q == netcfg_pkg::BTN_HELD) && btn_fall
                         && (hold_cnt_q >= HOLD_MIN_CYC) && (hold_cnt_q <= HOLD_MAX_CYC);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      btn_prev_q <= 1'b0;
    else
      btn_prev_q <= btn_s;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      btn_state_q <= netcfg_pkg::BTN_IDLE;
      hold_cnt_q  <= '0;
    end
    else
    begin
      case (btn_state_q)
        netcfg_pkg::BTN_IDLE:
        begin
          hold_cnt_q <= '0;
          if (btn_rise)
            btn_state_q <= netcfg_pkg::BTN_HELD;
        end
        netcfg_pkg::BTN_HELD:
        begin
          hold_cnt_q <= hold_cnt_q + 32'h1;
          if (pending_enter)
            btn_state_q <= netcfg_pkg::BTN_PENDING;
          else if (btn_fall)
            btn_state_q <= netcfg_pkg::BTN_IDLE;
          else if (hold_cnt_q > HOLD_MAX_CYC)
            btn_state_q <= netcfg_pkg::BTN_WAIT_RELEASE;
        end
        netcfg_pkg::BTN_WAIT_RELEASE:
        begin
          // Held too long: ignored until the button is let go
          if (!btn_s)
            btn_state_q <= netcfg_pkg::BTN_IDLE;
        end
        netcfg_pkg::BTN_PENDING:
        begin
          if (btn_rise)
            btn_state_q <= netcfg_pkg::BTN_RESTORE;
        end
        netcfg_pkg::BTN_RESTORE:
          btn_state_q <= netcfg_pkg::BTN_REBOOT;
        netcfg_pkg::BTN_REBOOT:
          // Only the reset that the reboot brings leaves this state
          btn_state_q <= netcfg_pkg::BTN_REBOOT;
        default:
          btn_state_q <= netcfg_pkg::BTN_IDLE;
      endcase
    end
  end

  // Regular flash: both lamps toggle together every half period
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      flash_cnt_q <= '0;
      flash_q     <= 1'b0;
    end
    else if (btn_state_q != netcfg_pkg::BTN_PENDING)
    begin
      flash_cnt_q <= '0;
      flash_q     <= 1'b1;
    end
    else if (flash_cnt_q >= FLASH_HALF_CYC - 1)
    begin
      flash_cnt_q <= '0;
      flash_q     <= !flash_q;
    end
    else
      flash_cnt_q <= flash_cnt_q + 32'h1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      factory_restore_o <= 1'b0;
      reboot_req_o      <= 1'b0;
      led_green_o       <= 1'b0;
      led_red_o         <= 1'b0;
    end
    else
    begin
      factory_restore_o <= (btn_state_q == netcfg_pkg::BTN_RESTORE);
      reboot_req_o      <= (btn_state_q == netcfg_pkg::BTN_REBOOT);
      case (btn_state_q)
        netcfg_pkg::BTN_PENDING:
        begin
          led_green_o <= flash_q;
          led_red_o   <= flash_q;
        end
        netcfg_pkg::BTN_RESTORE,
        netcfg_pkg::BTN_REBOOT:
        begin
          led_green_o <= 1'b0;
          led_red_o   <= 1'b0;
        end
        default:
        begin
          led_green_o <= link_s;
          led_red_o   <= rx_s;
        end
      endcase
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  logic [3:0] irq_status_q;
  logic [3:0] irq_mask_q;
  logic [3:0] irq_evt;
  logic [3:0] irq_clr;

  always_comb
  begin
    irq_evt                                 = '0;
    irq_evt[netcfg_pkg::IRQ_PENDING]        = pending_enter;
    irq_evt[netcfg_pkg::IRQ_RESTORE]        = (btn_state_q == netcfg_pkg::BTN_RESTORE);
    irq_evt[netcfg_pkg::IRQ_AUTO_RPT]       = auto_rpt;
    irq_evt[netcfg_pkg::IRQ_CONNECT_RPT]    = connect_rpt;
  end

  assign irq_clr = (wr_en_i && (addr_i == netcfg_pkg::REG_IRQ_STATUS))
                   ? wr_data_i[netcfg_pkg::IRQ_W-1:0] : 4'h0;

  // A new event in the clearing cycle wins over the clear
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      irq_status_q <= '0;
    else
      irq_status_q <= (irq_status_q & ~irq_clr) | irq_evt;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      irq_mask_q <= netcfg_pkg::IRQ_MASK_RST;
    else if (wr_en_i && (addr_i == netcfg_pkg::REG_IRQ_MASK))
      irq_mask_q <= wr_data_i[netcfg_pkg::IRQ_W-1:0];
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_status_q & irq_mask_q);
  end

  // ****************************************
  // Register read port
  // ****************************************
  logic [31:0] decode_word;

  always_comb
  begin
    decode_word                                    = '0;
    decode_word[netcfg_pkg::DEC_EMUL_LSB +: 2]     = emul_d;
    decode_word[netcfg_pkg::DEC_SENSOR]            = sensor_en;
    decode_word[netcfg_pkg::DEC_BUSY]              = busy_o;
    decode_word[netcfg_pkg::DEC_INIT_EN]           = init_en;
    decode_word[netcfg_pkg::DEC_AUTO_EN]           = auto_en;
    decode_word[netcfg_pkg::DEC_CONNECT_EN]        = connect_en;
    decode_word[netcfg_pkg::DEC_CFG_VALID]         = cfg_valid_q;
    decode_word[netcfg_pkg::DEC_BTN_LSB +: 3]      = btn_state_q;
  end

  // Read data stand only in the cycle after the strobe; unmapped reads return zero
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
      rd_data_o <= '0;
    else if (!rd_en_i)
      rd_data_o <= '0;
    else
    begin
      case (addr_i)
        netcfg_pkg::REG_CONFIG:     rd_data_o <= {18'h0, bank_b_q, bank_a_q};
        netcfg_pkg::REG_DECODE:     rd_data_o <= decode_word;
        netcfg_pkg::REG_IRQ_STATUS: rd_data_o <= {28'h0, irq_status_q};
        netcfg_pkg::REG_IRQ_MASK:   rd_data_o <= {28'h0, irq_mask_q};
        default:                    rd_data_o <= '0;
      endcase
    end
  end

endmodule

// ===== test/net_host_model.sv
// Purpose: Behavioural host on the network side of the board.
// Assumes: One clock shared with the decoder.
// Notes:   All levels change just after a rising edge.
`timescale 1ns/100ps
module net_host_model (
  input  wire logic ref_clk_i,
  output logic      link_100_o,
  output logic      rx_activity_o,
  output logic      port_connect_o
);
  // ********
  // Host actions
  // ********
  initial
  begin
    link_100_o = 1'b0;
    rx_activity_o = 1'b0;
    port_connect_o = 1'b0;
  end

  task automatic link(input logic v);
    @(posedge ref_clk_i);
    link_100_o <= v;
  endtask

  task automatic rx(input logic v);
    @(posedge ref_clk_i);
    rx_activity_o <= v;
  endtask

  // Delay lets a slow host open its connection late
  task automatic connect(input int d);
    repeat (d + 1) @(posedge ref_clk_i);
    port_connect_o <= 1'b1;
    @(posedge ref_clk_i);
    port_connect_o <= 1'b0;
  endtask
endmodule

// ===== test/netcfg_decoder_sva.sv
// Purpose: Port-level checks for the configuration decoder.
// Assumes: Switch pins held stable from reset until capture.
// Notes:   Config checks wait 12 cycles after reset for capture.
`timescale 1ns/100ps
module netcfg_decoder_sva #(
  parameter int unsigned HOLD_MIN_CYC   = netcfg_pkg::HOLD_MIN_CYC,
  parameter int unsigned HOLD_MAX_CYC   = netcfg_pkg::HOLD_MAX_CYC,
  parameter int unsigned FLASH_HALF_CYC = netcfg_pkg::FLASH_HALF_CYC
) (
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic [9:0]  config_switch_bank_a_i,
  input wire logic        offline_i,
  input wire logic        rx_buf_full_i,
  input wire logic        status_change_i,
  input wire logic        port_connect_i,
  input wire logic        rd_en_i,
  input wire logic [31:0] rd_data_o,
  input wire logic [1:0]  emulation_o,
  input wire logic        sensor_adjust_en_o,
  input wire logic        busy_o,
  input wire logic        status_report_o,
  input wire logic        init_reset_o,
  input wire logic        factory_restore_o,
  input wire logic        reboot_req_o,
  input wire logic        led_green_o,
  input wire logic        led_red_o
);
  // ********
  // Capture model
  // ********
  logic [3:0] age_q;
  logic [9:0] cfg_q;
  logic       cfg_ok;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  always_ff @(posedge ref_clk_i)
    if (!rst_b_i)
      age_q <= 4'h0;
    else if (age_q != 4'hf)
      age_q <= age_q + 4'h1;

  // Later switch moves must not reach the decode, so keep our own copy
  always_ff @(posedge ref_clk_i)
    if (!rst_b_i)
      cfg_q <= 10'h3ff;
    else if (age_q == 4'h3)
      cfg_q <= config_switch_bank_a_i;

  assign cfg_ok = (age_q >= 4'hc);

  // ********
  // Assertions
  // ********
  emul_decode_a:
    assert property (cfg_ok |-> emulation_o == ~cfg_q[1:0])
    else $error("emulation code wrong");
  sensor_level_a:
    assert property (cfg_ok |-> sensor_adjust_en_o == !cfg_q[3])
    else $error("sensor enable wrong");
  busy_cond_a:
    assert property (cfg_ok |=> busy_o == ($past(rx_buf_full_i)
                     | (cfg_q[5] & $past(offline_i))))
    else $error("busy level wrong");
  auto_report_a:
    assert property (cfg_ok && status_change_i && cfg_q[6] |=> status_report_o)
    else $error("status report missing");
  connect_report_a:
    assert property (cfg_ok && port_connect_i && cfg_q[7] && !emulation_o[1]
                     |=> status_report_o)
    else $error("connect report missing");
  report_cause_a:
    assert property (cfg_ok && status_report_o |-> $past(status_change_i && cfg_q[6]
                     || port_connect_i && cfg_q[7] && !emulation_o[1]))
    else $error("report without cause");
  init_gate_a:
    assert property (cfg_ok && init_reset_o |-> emulation_o == 2'h3 && cfg_q[4])
    else $error("init honoured wrongly");
  restore_then_a:
    assert property (factory_restore_o |=> reboot_req_o && !factory_restore_o)
    else $error("reboot not after restore");
  reboot_dark_a:
    assert property (reboot_req_o |-> !led_green_o && !led_red_o ##1 reboot_req_o)
    else $error("lamps lit or reboot dropped");
  read_idle_a:
    assert property (!$past(rd_en_i) |-> rd_data_o == 32'h0)
    else $error("read data outside slot");

  cover property (status_report_o);
  cover property (factory_restore_o ##1 reboot_req_o);
  cover property (init_reset_o);
endmodule

bind netcfg_decoder netcfg_decoder_sva #(
  .HOLD_MIN_CYC(HOLD_MIN_CYC),
  .HOLD_MAX_CYC(HOLD_MAX_CYC),
  .FLASH_HALF_CYC(FLASH_HALF_CYC)
) u_sva (
  .ref_clk_i, .rst_b_i, .config_switch_bank_a_i, .offline_i, .rx_buf_full_i,
  .status_change_i, .port_connect_i, .rd_en_i, .rd_data_o, .emulation_o,
  .sensor_adjust_en_o, .busy_o, .status_report_o, .init_reset_o,
  .factory_restore_o, .reboot_req_o, .led_green_o, .led_red_o
);

// ===== test/netcfg_decoder_tb.sv
// Purpose: Self-checking bench for the configuration decoder.
// Assumes: Short hold and flash counts set by parameter.
// Notes:   Each scenario resets with its own switch setting.
`timescale 1ns/100ps
module netcfg_decoder_tb;
  // ********
  // Design and host
  // ********
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [9:0]  sw = 10'h3ff;
  logic [3:0]  swb = 4'hf;
  logic        btn = 1'b0;
  logic        init_b = 1'b1;
  logic        offl = 1'b0;
  logic        full = 1'b0;
  logic        chg = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [1:0]  emul;
  logic        sens, busy, rpt, init_rst, rest, reboot, green, red, irq, link, rxa, conn;
  int          errors = 0;
  int          tests_run = 0;

  always #4 clk = ~clk;

  net_host_model u_host (.ref_clk_i(clk), .link_100_o(link), .rx_activity_o(rxa),
    .port_connect_o(conn));
  netcfg_decoder #(.HOLD_MIN_CYC(20), .HOLD_MAX_CYC(100), .FLASH_HALF_CYC(4)) u_dut (
    .ref_clk_i(clk), .rst_b_i(rst_b), .config_switch_bank_a_i(sw),
    .config_switch_bank_b_i(swb), .button_i(btn), .link_100_i(link),
    .rx_activity_i(rxa), .host_init_b_i(init_b), .offline_i(offl),
    .rx_buf_full_i(full), .status_change_i(chg), .port_connect_i(conn),
    .addr_i(addr), .wr_data_i(wdata), .wr_en_i(wr), .rd_en_i(rd), .rd_data_o(rdata),
    .emulation_o(emul), .sensor_adjust_en_o(sens), .busy_o(busy),
    .status_report_o(rpt), .init_reset_o(init_rst), .factory_restore_o(rest),
    .reboot_req_o(reboot), .led_green_o(green), .led_red_o(red), .irq_o(irq));

  // ********
  // Shared tasks
  // ********
  task automatic stop_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Switches move with reset so the capture sees them settled
  task automatic boot(input logic [9:0] s);
    @(posedge clk);
    rst_b <= 1'b0;
    sw <= s;
    cyc(2);
    rst_b <= 1'b1;
    cyc(14);
    #1;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic pulse_chg(input logic exp);
    @(posedge clk);
    chg <= 1'b1;
    @(posedge clk);
    chg <= 1'b0;
    #1 chk(32'(rpt), 32'(exp));
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_default;
    logic [31:0] d;
    boot(10'h3ff);
    chk(32'(emul), 32'h0);
    chk(32'(sens), 32'h0);
    @(posedge clk);
    sw <= 10'h000;
    swb <= 4'h5;
    cyc(12);
    #1 chk(32'(emul), 32'h0);
    rd_reg(netcfg_pkg::REG_CONFIG, d);
    chk(d, 32'h3fff);
    rd_reg(4'h2, d);
    chk(d, 32'h0);
  endtask

  task automatic t_emul;
    for (int i = 0; i < 4; i++)
    begin
      boot({6'h3f, i[0], 1'b1, i[1:0]});
      chk(32'(emul), 32'(3 - i));
      chk(32'(sens), 32'(1 - i % 2));
    end
  endtask

  task automatic t_busy;
    for (int i = 0; i < 8; i++)
    begin
      if (i % 4 == 0)
        boot(i < 4 ? 10'h3ff : 10'h3df);
      @(posedge clk);
      offl <= i[0];
      full <= i[1];
      cyc(2);
      #1 chk(32'(busy), 32'(i[1] | (i[0] & (i < 4))));
    end
    @(posedge clk);
    offl <= 1'b0;
    full <= 1'b0;
  endtask

  task automatic t_reports;
    logic [31:0] d;
    boot(10'h3ff);
    wr_reg(netcfg_pkg::REG_IRQ_MASK, 32'hc);
    rd_reg(netcfg_pkg::REG_IRQ_MASK, d);
    chk(d, 32'hc);
    pulse_chg(1'b1);
    #8 chk(32'(irq), 32'h1);
    u_host.connect(3);
    #1 chk(32'(rpt), 32'h1);
    rd_reg(netcfg_pkg::REG_IRQ_STATUS, d);
    chk(d, 32'hc);
    wr_reg(netcfg_pkg::REG_IRQ_STATUS, 32'hc);
    rd_reg(netcfg_pkg::REG_IRQ_STATUS, d);
    chk(d, 32'h0);
    chk(32'(irq), 32'h0);
    boot(10'h3bc);
    pulse_chg(1'b0);
    u_host.connect(0);
    #1 chk(32'(rpt), 32'h0);
  endtask

  task automatic t_init;
    logic [9:0]  s[3] = '{10'h3fc, 10'h3ec, 10'h3ff};
    logic [31:0] d;
    for (int i = 0; i < 3; i++)
    begin
      boot(s[i]);
      rd_reg(netcfg_pkg::REG_CONFIG, d);
      chk(d, {18'h0, 4'h5, s[i]});
      @(posedge clk);
      init_b <= 1'b0;
      cyc(10);
      #1 chk(32'(init_rst), 32'(i == 0));
      @(posedge clk);
      init_b <= 1'b1;
      cyc(10);
      #1 chk(32'(init_rst), 32'h0);
    end
  endtask

  task automatic t_leds;
    boot(10'h3ff);
    u_host.link(1'b1);
    cyc(8);
    #1 chk(32'(green), 32'h1);
    chk(32'(red), 32'h0);
    u_host.rx(1'b1);
    u_host.link(1'b0);
    cyc(8);
    #1 chk(32'(red), 32'h1);
    chk(32'(green), 32'h0);
    u_host.rx(1'b0);
  endtask

  task automatic t_button;
    logic [31:0] d;
    int          hold[3] = '{5, 120, 30};
    logic [31:0] st[3] = '{32'h0, 32'h0, 32'h3};
    int          n;
    boot(10'h3ff);
    wr_reg(netcfg_pkg::REG_IRQ_MASK, 32'h3);
    foreach (hold[i])
    begin
      @(posedge clk);
      btn <= 1'b1;
      cyc(hold[i]);
      btn <= 1'b0;
      cyc(10);
      rd_reg(netcfg_pkg::REG_DECODE, d);
      chk((d >> 8) & 32'h7, st[i]);
    end
    n = 0;
    repeat (16)
    begin
      @(posedge clk);
      #1 n += int'(green);
      chk(32'(green), 32'(red));
    end
    chk(32'(n), 32'h8);
    chk(32'(irq), 32'h1);
    @(posedge clk);
    btn <= 1'b1;
    n = 0;
    while (rest !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 20)
    begin
      errors++;
      stop_test();
    end
    chk(32'(green | red), 32'h0);
    @(posedge clk);
    btn <= 1'b0;
    #1 chk(32'(reboot), 32'h1);
    rd_reg(netcfg_pkg::REG_IRQ_STATUS, d);
    chk(d, 32'h3);
  endtask

  initial
  begin
    t_default();
    t_emul();
    t_busy();
    t_reports();
    t_init();
    t_leds();
    t_button();
    stop_test();
  end

  initial
  begin
    cyc(20000);
    errors++;
    stop_test();
  end
endmodule
